// ==== core/mel_motion_event_latch.sv ====
// Motion event latch: trigger capture, flags, monitors, APB access.
// Assumes motion inputs on pclk; clear and advance are raw pins.
`timescale 1ns/1ps
module mel_motion_event_latch
#(
   parameter int POS_W = 32,
   parameter int OPN_W = 8,
   parameter int LOOP_W = 16,
   parameter int LOAD_W = 16
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [mel_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic capture_clear_input,
   input wire logic step_advance_input,
   input wire logic sd_active,
   input wire logic advance_switches,
   input wire logic low_event_jump,
   input wire logic high_event_jump,
   input wire logic [mel_pkg::STOP_W-1:0] stop_cause,
   input wire logic moving_forward,
   input wire logic moving_reverse,
   input wire logic [POS_W-1:0] cmd_pos,
   input wire logic [POS_W-1:0] fb_pos,
   input wire logic [POS_W-1:0] dest_target,
   input wire logic [POS_W-1:0] stop_target,
   input wire logic [OPN_W-1:0] op_number,
   input wire logic loop_active,
   input wire logic [LOOP_W-1:0] loop_count,
   input wire logic in_motion,
   input wire logic load_valid,
   input wire logic [LOAD_W-1:0] load_sample,
   output logic advance_captured_flag,
   output logic low_event_captured_flag,
   output logic high_event_captured_flag,
   output logic irq
);
   import mel_pkg::*;

   // ********************************************************
   // Declarations
   // ********************************************************
   logic clr_rise;
   logic adv_rise;
   logic [STOP_W-1:0] stop_hit;
   logic [NUM_CAT-1:0] trig;
   logic [NUM_CAT-1:0] la_stat;
   logic [POS_W-1:0] ev_cmd [NUM_CAT];
   logic [POS_W-1:0] ev_fb [NUM_CAT];
   logic [POS_W-1:0] la_cmd [NUM_CAT];
   logic [POS_W-1:0] la_fb [NUM_CAT];
   logic [POS_W-1:0] la_tgt [NUM_CAT];
   logic [OPN_W-1:0] la_opn [NUM_CAT];
   logic [LOOP_W-1:0] la_loop [NUM_CAT];
   logic [POS_W-1:0] snap_tgt [NUM_CAT];
   logic [LOOP_W-1:0] snap_loop;
   logic auto_clear;
   logic [31:0] cum_load;
   logic [NUM_CAT-1:0] irq_stat;
   logic [NUM_CAT-1:0] irq_mask;
   logic [NUM_CAT-1:0] irq_set;
   mel_apb_state_t apb_state;
   logic [31:0] rd_data;
   logic rd_ok;
   logic wr_take;

   // ********************************************************
   // Address helpers
   // ********************************************************
   function automatic logic in_slots(input logic [ADDR_W-1:0] a);
      in_slots = (a < 8'(NUM_CAT * SLOT_STRIDE)) && (a[1:0] == 2'h0);
   endfunction

   function automatic logic [2:0] field_of(input logic [ADDR_W-1:0] a);
      field_of = a[4:2];
   endfunction

   function automatic logic [1:0] slot_of(input logic [ADDR_W-1:0] a);
      slot_of = a[6:5];
   endfunction

   // ********************************************************
   // Pin synchronisers
   // ********************************************************
   // (RULE_19) Clear pin edge
   mel_sync_edge u_clr_sync
   (
      .clk(pclk),
      .rst_n(presetn),
      .pin(capture_clear_input),
      .level(),
      .rise(clr_rise)
   );

   // (RULE_19) Advance pin edge
   mel_sync_edge u_adv_sync
   (
      .clk(pclk),
      .rst_n(presetn),
      .pin(step_advance_input),
      .level(),
      .rise(adv_rise)
   );

   // ********************************************************
   // Trigger sources
   // ********************************************************
   always_comb
   begin
      // (RULE_07) Input-caused stops
      // (RULE_08) Overtravel and alarm stops
      stop_hit = stop_cause;
      // (RULE_09) Block stops need direction
      stop_hit[STOP_FWD_BLOCK] = stop_cause[STOP_FWD_BLOCK]
                                 & moving_forward;
      stop_hit[STOP_REV_BLOCK] = stop_cause[STOP_REV_BLOCK]
                                 & moving_reverse;
   end

   always_comb
   begin
      // (RULE_06) Advance switches operation
      trig[CAT_ADV] = adv_rise & sd_active & advance_switches;
      // (RULE_05) Event jumps in stored data
      trig[CAT_LOW] = low_event_jump & sd_active;
      trig[CAT_HIGH] = high_event_jump & sd_active;
      trig[CAT_STOP] = |stop_hit;
   end

   // ********************************************************
   // Captured values
   // ********************************************************
   always_comb
   begin
      // (RULE_02) Target by trigger kind
      snap_tgt[CAT_ADV] = dest_target;
      snap_tgt[CAT_LOW] = dest_target;
      snap_tgt[CAT_HIGH] = dest_target;
      snap_tgt[CAT_STOP] = stop_target;
      // (RULE_03) Loop count only in loop
      snap_loop = loop_active ? loop_count : '0;
   end

   // ********************************************************
   // Event monitor
   // ********************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < NUM_CAT; i++)
         begin
            ev_cmd[i] <= '0;
            ev_fb[i] <= '0;
         end
      end
      else
      begin
         for (int i = 0; i < NUM_CAT; i++)
         begin
            // (RULE_15) Overwrite on every trigger
            if (trig[i])
            begin
               ev_cmd[i] <= cmd_pos;
               ev_fb[i] <= fb_pos;
            end
            // (RULE_11) Clear zeroes positions
            else if (clr_rise)
            begin
               ev_cmd[i] <= '0;
               ev_fb[i] <= '0;
            end
         end
      end
   end

   // ********************************************************
   // Latch monitor
   // ********************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      // (RULE_04) Power-up clears captures
      if (!presetn)
      begin
         la_stat <= '0;
         for (int i = 0; i < NUM_CAT; i++)
         begin
            la_cmd[i] <= '0;
            la_fb[i] <= '0;
            la_tgt[i] <= '0;
            la_opn[i] <= '0;
            la_loop[i] <= '0;
         end
      end
      else
      begin
         for (int i = 0; i < NUM_CAT; i++)
         begin
            // (RULE_16) First capture only
            // (RULE_19) Clear then capture
            if (trig[i] && (!la_stat[i] || clr_rise))
            begin
               // (RULE_01) Capture motion snapshot
               la_stat[i] <= 1'b1;
               la_cmd[i] <= cmd_pos;
               la_fb[i] <= fb_pos;
               la_tgt[i] <= snap_tgt[i];
               la_opn[i] <= op_number;
               la_loop[i] <= snap_loop;
            end
            // (RULE_11) Clear latch status
            else if (clr_rise)
               la_stat[i] <= 1'b0;
         end
      end
   end

   // ********************************************************
   // Latched flag outputs
   // ********************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         advance_captured_flag <= 1'b0;
      // (RULE_14) Advance edge sets flag
      else if (adv_rise)
         advance_captured_flag <= 1'b1;
      // (RULE_10) Clear edge drops flag
      else if (clr_rise)
         advance_captured_flag <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         low_event_captured_flag <= 1'b0;
         high_event_captured_flag <= 1'b0;
      end
      else
      begin
         // (RULE_13) Event triggers set flags
         if (trig[CAT_LOW])
            low_event_captured_flag <= 1'b1;
         // (RULE_10) Clear edge drops flag
         else if (clr_rise)
            low_event_captured_flag <= 1'b0;
         if (trig[CAT_HIGH])
            high_event_captured_flag <= 1'b1;
         else if (clr_rise)
            high_event_captured_flag <= 1'b0;
      end
   end

   // ********************************************************
   // Cumulative load
   // ********************************************************
   mel_load_accum #(.LOAD_W(LOAD_W)) u_load
   (
      .clk(pclk),
      .rst_n(presetn),
      .auto_clear(auto_clear),
      .in_motion(in_motion),
      .clear_req(clr_rise),
      .sample_valid(load_valid),
      .sample(load_sample),
      .total(cum_load)
   );

   // ********************************************************
   // Interrupts
   // ********************************************************
   assign irq_set = {trig[CAT_STOP], trig[CAT_HIGH],
                     trig[CAT_LOW], adv_rise};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_stat <= '0;
      else if (wr_take && paddr == ADDR_IRQ_STAT)
         irq_stat <= (irq_stat & ~pwdata[NUM_CAT-1:0]) | irq_set;
      else
         irq_stat <= irq_stat | irq_set;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq <= 1'b0;
      else
         irq <= |(irq_stat & irq_mask);
   end

   // ********************************************************
   // Writable configuration
   // ********************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         auto_clear <= CTRL_AUTO_CLR_RST;
         irq_mask <= IRQ_MASK_RST;
      end
      else if (wr_take)
      begin
         if (paddr == ADDR_CTRL)
            auto_clear <= pwdata[CTRL_AUTO_CLR_BIT];
         if (paddr == ADDR_IRQ_MASK)
            irq_mask <= pwdata[NUM_CAT-1:0];
      end
   end

   // ********************************************************
   // Read decode
   // ********************************************************
   // (RULE_17) Monitors readable by host
   always_comb
   begin
      rd_data = '0;
      rd_ok = 1'b1;
      if (in_slots(paddr))
      begin
         case (field_of(paddr))
            F_EV_CMD: rd_data = 32'(ev_cmd[slot_of(paddr)]);
            F_EV_FB: rd_data = 32'(ev_fb[slot_of(paddr)]);
            F_LA_STAT: rd_data = 32'(la_stat[slot_of(paddr)]);
            F_LA_CMD: rd_data = 32'(la_cmd[slot_of(paddr)]);
            F_LA_FB: rd_data = 32'(la_fb[slot_of(paddr)]);
            F_LA_TGT: rd_data = 32'(la_tgt[slot_of(paddr)]);
            F_LA_OPN: rd_data = 32'(la_opn[slot_of(paddr)]);
            F_LA_LOOP: rd_data = 32'(la_loop[slot_of(paddr)]);
            default: rd_data = '0;
         endcase
      end
      else
      begin
         case (paddr)
            ADDR_CTRL: rd_data = 32'(auto_clear);
            ADDR_CUM_LOAD: rd_data = cum_load;
            ADDR_IRQ_STAT: rd_data = 32'(irq_stat);
            ADDR_IRQ_MASK: rd_data = 32'(irq_mask);
            ADDR_FLAGS: rd_data = 32'({la_stat,
                                        high_event_captured_flag,
                                        low_event_captured_flag,
                                        advance_captured_flag});
            default: rd_ok = 1'b0;
         endcase
      end
   end

   // ********************************************************
   // APB slave
   // ********************************************************
   assign wr_take = (apb_state == APB_DONE) && psel && penable
                    && pwrite && !pslverr;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         apb_state <= APB_IDLE;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end
      else
      begin
         case (apb_state)
            APB_IDLE:
            begin
               if (psel && penable)
               begin
                  apb_state <= APB_DONE;
                  pready <= 1'b1;
                  pslverr <= !rd_ok;
                  prdata <= pwrite ? '0 : rd_data;
               end
            end
            APB_DONE:
            begin
               apb_state <= APB_IDLE;
               pready <= 1'b0;
               pslverr <= 1'b0;
            end
            default:
            begin
               apb_state <= APB_IDLE;
               pready <= 1'b0;
               pslverr <= 1'b0;
            end
         endcase
      end
   end

endmodule

// ==== core/mel_pkg.sv ====
// Constants, types and register map of the motion event latch.
// Assumes one APB clock domain; motion inputs arrive on that clock.
//
// Functional notes
// (RULE_01) Trigger captures positions, target, data number, loop
// (RULE_02) Jump/advance: destination target; stop: stopped target
// (RULE_03) Loop count stored only during loop operation
// (RULE_04) Captures persist until cleared; power-up clears
// (RULE_05) Low/high event jump in stored-data operation triggers
// (RULE_06) Step-advance switching stored-data operation triggers
// (RULE_07) Stops by excite/release/deviation/deexcite/stop inputs trigger
// (RULE_08) Overtravel or alarm stops trigger
// (RULE_09) Block-input stops trigger only in that direction
// (RULE_10) Clear edge clears status and three flags
// (RULE_11) Clear zeroes latch status and event positions
// (RULE_12) Clear resets cumulative load when auto-clear off
// (RULE_13) Low/high event triggers set their flags
// (RULE_14) Advance edge sets flag until clear edge
// (RULE_15) Event monitor overwritten on every trigger
// (RULE_16) Latch monitor keeps first capture while status set
// (RULE_17) Monitors readable by host over fieldbus
// (RULE_18) Auto-clear zeroes load at each motion start
// (RULE_19) Inputs synchronised; clear before same-cycle capture

package mel_pkg;

   // ********************************************************
   // Sizes and categories
   // ********************************************************
   localparam int ADDR_W = 8;
   localparam int NUM_CAT = 4;
   localparam int CAT_ADV = 0;
   localparam int CAT_LOW = 1;
   localparam int CAT_HIGH = 2;
   localparam int CAT_STOP = 3;
   localparam int SYNC_STAGES = 3;

   // ********************************************************
   // Stop causes
   // ********************************************************
   localparam int STOP_W = 10;
   localparam int STOP_EXCITE = 0;
   localparam int STOP_RELEASE = 1;
   localparam int STOP_DEV_RESET = 2;
   localparam int STOP_DEEXCITE = 3;
   localparam int STOP_PLAIN = 4;
   localparam int STOP_SOFT_OT = 5;
   localparam int STOP_HARD_OT = 6;
   localparam int STOP_ALARM = 7;
   localparam int STOP_FWD_BLOCK = 8;
   localparam int STOP_REV_BLOCK = 9;

   // ********************************************************
   // Register map
   // ********************************************************
   localparam logic [7:0] SLOT_STRIDE = 8'h20;
   localparam logic [2:0] F_EV_CMD = 3'h0;
   localparam logic [2:0] F_EV_FB = 3'h1;
   localparam logic [2:0] F_LA_STAT = 3'h2;
   localparam logic [2:0] F_LA_CMD = 3'h3;
   localparam logic [2:0] F_LA_FB = 3'h4;
   localparam logic [2:0] F_LA_TGT = 3'h5;
   localparam logic [2:0] F_LA_OPN = 3'h6;
   localparam logic [2:0] F_LA_LOOP = 3'h7;
   localparam logic [7:0] ADDR_CTRL = 8'h80;
   localparam logic [7:0] ADDR_CUM_LOAD = 8'h84;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h88;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h8C;
   localparam logic [7:0] ADDR_FLAGS = 8'h90;
   localparam int CTRL_AUTO_CLR_BIT = 0;
   localparam logic CTRL_AUTO_CLR_RST = 1'b1;
   localparam logic [3:0] IRQ_MASK_RST = 4'h0;
   localparam logic [31:0] CUM_LIMIT = 32'h7FFFFFFF;

   typedef enum logic {
      APB_IDLE = 1'b0,
      APB_DONE = 1'b1
   } mel_apb_state_t;

endpackage

// ==== core/mel_sync_edge.sv ====
// Three-stage synchroniser with rising-edge detection for a pin.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ps
module mel_sync_edge
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin,
   output logic level,
   output logic rise
);
   import mel_pkg::*;

   logic [SYNC_STAGES-1:0] sync;

   // (RULE_19) Synchronise pin
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         sync <= '0;
      else
         sync <= {sync[SYNC_STAGES-2:0], pin};
   end

   // (RULE_19) Agreed level and edge
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         level <= 1'b0;
         rise <= 1'b0;
      end
      else
      begin
         rise <= 1'b0;
         if (sync[1] == sync[2] && sync[2] != level)
         begin
            level <= sync[2];
            rise <= sync[2];
         end
      end
   end

endmodule

// ==== core/mel_load_accum.sv ====
// Saturating cumulative load accumulator with two clear modes.
// Assumes all inputs on clk; in_motion is a level.
`timescale 1ns/1ps
module mel_load_accum
#(
   parameter int LOAD_W = 16
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic auto_clear,
   input wire logic in_motion,
   input wire logic clear_req,
   input wire logic sample_valid,
   input wire logic [LOAD_W-1:0] sample,
   output logic [31:0] total
);
   import mel_pkg::*;

   logic motion_d;
   logic [32:0] sum;

   assign sum = {1'b0, total} + 33'(sample);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         motion_d <= 1'b0;
      else
         motion_d <= in_motion;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         total <= '0;
      // (RULE_18) Zero on motion start
      else if (auto_clear && in_motion && !motion_d)
         total <= '0;
      // (RULE_12) Clear only without auto-clear
      else if (clear_req && !auto_clear)
         total <= '0;
      else if (sample_valid)
      begin
         if (sum > {1'b0, CUM_LIMIT})
            total <= CUM_LIMIT;
         else
            total <= sum[31:0];
      end
   end

endmodule

// ==== verif/mel_host_model.sv ====
// Host controller model driving the discrete clear and advance pins.
// Assumes pclk is the drive clock; callers enter just after an edge.
`timescale 1ns/1ps
module mel_host_model
(
   input wire logic pclk,
   output logic capture_clear_input,
   output logic step_advance_input
);
   initial
   begin
      capture_clear_input = 1'h0;
      step_advance_input = 1'h0;
   end
   task automatic pulse(input logic clr, input logic adv);
      @(posedge pclk);
      capture_clear_input <= clr;
      step_advance_input <= adv;
      repeat (8) @(posedge pclk);
      capture_clear_input <= 1'h0;
      step_advance_input <= 1'h0;
      repeat (8) @(posedge pclk);
   endtask
endmodule

// ==== verif/mel_latch_monitor.sv ====
// Checker of the motion event latch ports, bound to the top module.
// Assumes pclk is the only clock and presetn an async low reset.
`timescale 1ns/1ps
module mel_latch_monitor
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic capture_clear_input,
   input wire logic step_advance_input,
   input wire logic sd_active,
   input wire logic low_event_jump,
   input wire logic high_event_jump,
   input wire logic advance_captured_flag,
   input wire logic low_event_captured_flag,
   input wire logic high_event_captured_flag
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_low_flag_set: assert property (
      sd_active && low_event_jump |=> low_event_captured_flag)
      else $error("low flag not set");
   a_high_flag_set: assert property (
      sd_active && high_event_jump |=> high_event_captured_flag)
      else $error("high flag not set");
   a_low_flag_hold: assert property (
      $fell(low_event_captured_flag) |-> $past(capture_clear_input, 3))
      else $error("low flag fell without clear");
   a_adv_flag_rise: assert property (
      $rose(advance_captured_flag) |-> $past(step_advance_input, 3))
      else $error("advance flag rose without edge");
   a_adv_flag_hold: assert property (
      $fell(advance_captured_flag) |-> $past(capture_clear_input, 3))
      else $error("advance flag fell without clear");
   a_ready_one_cycle: assert property (
      pready |=> !pready)
      else $error("ready held too long");
   a_ready_latency: assert property (
      psel && penable && !pready |=> pready)
      else $error("ready late");
   a_error_with_ready: assert property (
      pslverr |-> pready && psel && penable)
      else $error("error outside access");
endmodule

bind mel_motion_event_latch mel_latch_monitor u_mon
(
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr),
   .capture_clear_input(capture_clear_input),
   .step_advance_input(step_advance_input), .sd_active(sd_active),
   .low_event_jump(low_event_jump), .high_event_jump(high_event_jump),
   .advance_captured_flag(advance_captured_flag),
   .low_event_captured_flag(low_event_captured_flag),
   .high_event_captured_flag(high_event_captured_flag)
);

// ==== verif/testbench.sv ====
// Self-checking bench of the motion event latch, random stimulus.
// Assumes package, host model and checker are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) check(32'(g), 32'(e))
module testbench;
   import mel_pkg::*;
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, clr, adv, aflag, lflag, hflag, irq, erv;
   logic sd = 1'h1;
   logic asw = 1'h1;
   logic ljmp = 1'h0;
   logic hjmp = 1'h0;
   logic [9:0] stop = 10'h0;
   logic fwd = 1'h0;
   logic rev = 1'h0;
   logic [31:0] cmd = 32'h0, fb = 32'h0, dtgt = 32'h0, stgt = 32'h0;
   logic [7:0] opn = 8'h0;
   logic lact = 1'h0;
   logic [15:0] lcnt = 16'h0;
   logic mot = 1'h0;
   logic lv = 1'h0;
   logic [15:0] ls = 16'h0;
   logic [31:0] rdv, e_cmd, e_fb, l_cmd, l_fb, l_tgt, l_opn, l_loop, sum;
   int errors = 0;
   int n_compared = 0;
   int c, b, k, r;
   always #5 pclk = ~pclk;
   mel_motion_event_latch uut
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .capture_clear_input(clr),
      .step_advance_input(adv), .sd_active(sd), .advance_switches(asw),
      .low_event_jump(ljmp), .high_event_jump(hjmp), .stop_cause(stop),
      .moving_forward(fwd), .moving_reverse(rev), .cmd_pos(cmd),
      .fb_pos(fb), .dest_target(dtgt), .stop_target(stgt),
      .op_number(opn), .loop_active(lact), .loop_count(lcnt),
      .in_motion(mot), .load_valid(lv), .load_sample(ls),
      .advance_captured_flag(aflag), .low_event_captured_flag(lflag),
      .high_event_captured_flag(hflag), .irq(irq)
   );
   mel_host_model host
   (
      .pclk(pclk), .capture_clear_input(clr), .step_advance_input(adv)
   );
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e)
      begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      for (n = 0; n < 20 && pready !== 1'h1; n++)
         @(posedge pclk);
      if (n == 20)
      begin
         errors++;
         end_of_test();
      end
      rdv = prdata;
      erv = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0);
      `CHK(rdv, e);
   endtask
   function automatic logic [7:0] ad(input int t, input logic [2:0] f);
      return 8'(t) * SLOT_STRIDE + {3'h0, f, 2'h0};
   endfunction
   function automatic logic [31:0] exp_tgt(input int t);
      return (t == CAT_STOP) ? stgt : dtgt;
   endfunction
   task automatic rnd();
      @(posedge pclk);
      cmd <= $urandom;
      fb <= $urandom;
      dtgt <= $urandom;
      stgt <= $urandom;
      opn <= 8'($urandom);
      lact <= 1'($urandom);
      lcnt <= 16'($urandom);
      @(posedge pclk);
   endtask
   task automatic snap(input int t, input logic la);
      e_cmd = cmd;
      e_fb = fb;
      if (la)
      begin
         l_cmd = cmd;
         l_fb = fb;
         l_tgt = exp_tgt(t);
         l_opn = 32'(opn);
         l_loop = lact ? 32'(lcnt) : 32'h0;
      end
   endtask
   task automatic fire(input int t, input int s);
      ljmp <= (t == CAT_LOW);
      hjmp <= (t == CAT_HIGH);
      stop <= (t == CAT_STOP) ? 10'h1 << s : 10'h0;
      @(posedge pclk);
      ljmp <= 1'h0;
      hjmp <= 1'h0;
      stop <= 10'h0;
      repeat (3) @(posedge pclk);
   endtask
   task automatic chk_slot(input int t);
      rdc(ad(t, F_EV_CMD), e_cmd);
      rdc(ad(t, F_EV_FB), e_fb);
      rdc(ad(t, F_LA_STAT), 32'h1);
      rdc(ad(t, F_LA_CMD), l_cmd);
      rdc(ad(t, F_LA_FB), l_fb);
      rdc(ad(t, F_LA_TGT), l_tgt);
      rdc(ad(t, F_LA_OPN), l_opn);
      rdc(ad(t, F_LA_LOOP), l_loop);
   endtask
   task automatic acc();
      repeat (4)
      begin
         @(posedge pclk);
         r = $urandom_range(0, 65535);
         lv <= 1'h1;
         ls <= 16'(r);
         sum += 32'(r);
      end
      @(posedge pclk);
      lv <= 1'h0;
      repeat (3) @(posedge pclk);
   endtask
   initial
   begin
      void'($urandom(32'h078B));
      repeat (16) @(posedge pclk);
      presetn <= 1'h1;
      rdc(ADDR_CTRL, 32'h1);
      rdc(ADDR_FLAGS, 32'h0);
      apb(1'h0, 8'hA0, 32'h0);
      `CHK(erv, 1'h1);
      $display("test reset done");
      for (c = CAT_LOW; c <= CAT_STOP; c++)
      begin
         for (k = 0; k < 2; k++)
         begin
            rnd();
            snap(c, k == 0);
            fire(c, STOP_ALARM);
         end
         chk_slot(c);
      end
      `CHK({aflag, lflag, hflag}, 3'h3);
      host.pulse(1'h1, 1'h0);
      `CHK({aflag, lflag, hflag}, 3'h0);
      rdc(ADDR_FLAGS, 32'h0);
      rdc(ad(CAT_STOP, F_EV_FB), 32'h0);
      sd <= 1'h0;
      fire(CAT_LOW, 0);
      rdc(ad(CAT_LOW, F_LA_STAT), 32'h0);
      sd <= 1'h1;
      $display("test capture done");
      for (b = 0; b < STOP_W; b++)
      begin
         host.pulse(1'h1, 1'h0);
         fwd <= (b == STOP_FWD_BLOCK);
         rev <= (b == STOP_REV_BLOCK);
         rnd();
         snap(CAT_STOP, 1'h1);
         fire(CAT_STOP, b);
         chk_slot(CAT_STOP);
      end
      host.pulse(1'h1, 1'h0);
      fwd <= 1'h0;
      rev <= 1'h1;
      fire(CAT_STOP, STOP_FWD_BLOCK);
      rdc(ad(CAT_STOP, F_LA_STAT), 32'h0);
      $display("test stop done");
      asw <= 1'h0;
      host.pulse(1'h0, 1'h1);
      `CHK(aflag, 1'h1);
      rdc(ad(CAT_ADV, F_LA_STAT), 32'h0);
      host.pulse(1'h1, 1'h0);
      asw <= 1'h1;
      rnd();
      snap(CAT_ADV, 1'h1);
      host.pulse(1'h0, 1'h1);
      chk_slot(CAT_ADV);
      `CHK(aflag, 1'h1);
      $display("test advance done");
      `CHK(irq, 1'h0);
      apb(1'h1, ADDR_IRQ_MASK, 32'hF);
      repeat (2) @(posedge pclk);
      `CHK(irq, 1'h1);
      apb(1'h1, ADDR_IRQ_STAT, 32'hF);
      repeat (2) @(posedge pclk);
      `CHK(irq, 1'h0);
      rdc(ADDR_IRQ_STAT, 32'h0);
      fire(CAT_HIGH, 0);
      `CHK(irq, 1'h1);
      apb(1'h1, ADDR_IRQ_MASK, 32'h0);
      repeat (2) @(posedge pclk);
      `CHK(irq, 1'h0);
      rnd();
      snap(CAT_HIGH, 1'h1);
      fork
         host.pulse(1'h1, 1'h0);
         begin
            repeat (5) @(posedge pclk);
            fire(CAT_HIGH, 0);
         end
      join
      chk_slot(CAT_HIGH);
      `CHK(hflag, 1'h1);
      $display("test irq done");
      sum = 32'h0;
      acc();
      host.pulse(1'h1, 1'h0);
      rdc(ADDR_CUM_LOAD, sum);
      mot <= 1'h1;
      repeat (3) @(posedge pclk);
      rdc(ADDR_CUM_LOAD, 32'h0);
      apb(1'h1, ADDR_CTRL, 32'h0);
      mot <= 1'h0;
      sum = 32'h0;
      acc();
      mot <= 1'h1;
      repeat (3) @(posedge pclk);
      rdc(ADDR_CUM_LOAD, sum);
      host.pulse(1'h1, 1'h0);
      rdc(ADDR_CUM_LOAD, 32'h0);
      $display("test load done");
      end_of_test();
   end
endmodule
